// File: design/atc_dev.sv
`timescale 1ns/10ps
module atc_dev #(
    parameter int CW = 24
) (
    input  wire logic        mclk,
    input  wire logic        rst_n,
    input  wire logic        ce,
    input  wire logic [7:0]  addr,
    input  wire logic [31:0] wdata,
    input  wire logic        wr,
    input  wire logic        rd,
    output logic      [31:0] rdata,
    atc_if.dev               pins
);
    import atc_pkg::*;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic sel_lvl(input logic [7:0] v, input logic [3:0] src, input logic pol);
        sel_lvl = src[3] ? 1'b0 : (v[src[2:0]] ^ pol);
    endfunction : sel_lvl

    function automatic logic [3:0] src_of(input logic [NUM_SIGS*4-1:0] r, input int idx);
        src_of = r[idx*4 +: 4];
    endfunction : src_of

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic [CTRL_W-1:0]     ctrl_q;
    logic [NUM_SIGS*4-1:0] route_q;
    logic [NUM_SIGS-1:0]   pol_q;
    logic [CW-1:0]         scan_ivl_q;
    logic [CW-1:0]         conv_ivl_q;
    logic [CW-1:0]         pre_q;
    logic [CW-1:0]         post_q;
    logic [CW-1:0]         conv_num_q;
    logic [31:0]           rdata_q;
    atc_seq_t              seq_q;
    logic [CW-1:0]         remain_q;
    logic                  in_scan_q;

    logic cmd_start;
    logic cmd_stop;
    assign cmd_start = wr && (addr == REG_CMD) && wdata[CMD_START];
    assign cmd_stop  = wr && (addr == REG_CMD) && wdata[CMD_STOP];

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_q     <= CTRL_RST;
            route_q    <= ROUTE_RST;
            pol_q      <= POL_RST;
            scan_ivl_q <= IVL_RST[CW-1:0];
            conv_ivl_q <= IVL_RST[CW-1:0];
            pre_q      <= COUNT_RST[CW-1:0];
            post_q     <= COUNT_RST[CW-1:0];
            conv_num_q <= COUNT_RST[CW-1:0];
        end else if (ce && wr) begin
            case (addr)
                REG_CTRL:     ctrl_q     <= wdata[CTRL_W-1:0];
                REG_ROUTE:    route_q    <= wdata[NUM_SIGS*4-1:0];
                REG_POL:      pol_q      <= wdata[NUM_SIGS-1:0];
                REG_SCAN_IVL: scan_ivl_q <= wdata[CW-1:0];
                REG_CONV_IVL: conv_ivl_q <= wdata[CW-1:0];
                REG_PRE_CNT:  pre_q      <= wdata[CW-1:0];
                REG_POST_CNT: post_q     <= wdata[CW-1:0];
                REG_CONV_NUM: conv_num_q <= wdata[CW-1:0];
                default: ;
            endcase
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_q <= 32'h0000_0000;
        end else if (ce) begin
            rdata_q <= 32'h0000_0000;
            if (rd) begin
                case (addr)
                    REG_CTRL:     rdata_q <= 32'(ctrl_q);
                    REG_ROUTE:    rdata_q <= 32'(route_q);
                    REG_POL:      rdata_q <= 32'(pol_q);
                    REG_SCAN_IVL: rdata_q <= 32'(scan_ivl_q);
                    REG_CONV_IVL: rdata_q <= 32'(conv_ivl_q);
                    REG_PRE_CNT:  rdata_q <= 32'(pre_q);
                    REG_POST_CNT: rdata_q <= 32'(post_q);
                    REG_CONV_NUM: rdata_q <= 32'(conv_num_q);
                    REG_STATUS:   rdata_q <= {29'h0, in_scan_q, seq_q};
                    REG_REMAIN:   rdata_q <= 32'(remain_q);
                    default:      rdata_q <= 32'h0000_0000;
                endcase
            end
        end
    end
    assign rdata = rdata_q;

    // ------------------------------------------------------------
    // Input synchronisers and detection
    // ------------------------------------------------------------
    logic [7:0] sync1_q;
    logic [7:0] sync2_q;
    logic [7:0] sync3_q;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            sync1_q <= 8'h00;
            sync2_q <= 8'h00;
            sync3_q <= 8'h00;
        end else if (ce) begin
            sync1_q <= pins.trig;
            sync2_q <= sync1_q;
            sync3_q <= sync2_q;
        end
    end

    logic [NUM_SIGS-1:0] lvl;
    logic [NUM_SIGS-1:0] edg;
    always_comb begin
        for (int i = 0; i < NUM_SIGS; i++) begin
            lvl[i] = sel_lvl(sync2_q, src_of(route_q, i), pol_q[i]);
            edg[i] = lvl[i] & ~sel_lvl(sync3_q, src_of(route_q, i), pol_q[i]);
        end
    end

    function automatic logic is_int(input logic [NUM_SIGS*4-1:0] r, input int idx);
        logic [3:0] s;
        s      = src_of(r, idx);
        is_int = s[3];
    endfunction : is_int

    // ------------------------------------------------------------
    // Timebase and scan interval counter
    // ------------------------------------------------------------
    logic [9:0]    tb_cnt_q;
    logic [CW-1:0] si_q;
    logic          tb_tick;
    logic          active;
    logic          scan_req;
    logic          scan_go;
    logic          conv_go;
    logic          last_conv;
    logic          start_ev;
    logic          ref_ev;

    assign active = (seq_q != ATC_IDLE);
    // External timebase is edge-detected; each active-going transition is one tick
    assign tb_tick = is_int(route_q, SIG_TBASE) ? (tb_cnt_q == 10'h000) : edg[SIG_TBASE];

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            tb_cnt_q <= 10'h000;
        end else if (ce) begin
            if (tb_cnt_q == 10'h000) begin
                tb_cnt_q <= ctrl_q[CTRL_TB_SLOW] ? 10'(TB_SLOW_CYC - 1) : 10'(TB_FAST_CYC - 1);
            end else begin
                tb_cnt_q <= tb_cnt_q - 10'h001;
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            si_q <= '0;
        end else if (ce) begin
            if (!active) begin
                si_q <= scan_ivl_q;
            end else if (tb_tick) begin
                si_q <= (si_q == '0) ? scan_ivl_q : si_q - 1'b1;
            end
        end
    end

    assign scan_req = is_int(route_q, SIG_SCAN) ? (active && tb_tick && si_q == '0) : edg[SIG_SCAN];
    // Gate is sampled only where a scan would begin
    assign scan_go  = scan_req && active && !in_scan_q && remain_q != '0 && seq_q != ATC_IDLE
                      && !lvl[SIG_GATE] && !ctrl_q[CTRL_SW_GATE];

    // ------------------------------------------------------------
    // Acquisition sequencer
    // ------------------------------------------------------------
    assign start_ev = (seq_q == ATC_IDLE) &&
                      (is_int(route_q, SIG_START) ? cmd_start : edg[SIG_START]);
    assign ref_ev   = (seq_q == ATC_WAIT_REF) && edg[SIG_REF];

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            seq_q    <= ATC_IDLE;
            remain_q <= '0;
        end else if (ce) begin
            if (cmd_stop) begin
                seq_q <= ATC_IDLE;
            end else begin
                case (seq_q)
                    ATC_IDLE: begin
                        if (start_ev) begin
                            seq_q    <= ctrl_q[CTRL_PRETRIG] ? ATC_PRE : ATC_POST;
                            remain_q <= ctrl_q[CTRL_PRETRIG] ? pre_q : post_q;
                        end
                    end
                    ATC_PRE: begin
                        if (remain_q == '0) begin
                            seq_q    <= ATC_WAIT_REF;
                            remain_q <= post_q;
                        end else if (scan_go) begin
                            remain_q <= remain_q - 1'b1;
                        end
                    end
                    ATC_WAIT_REF: begin
                        if (ref_ev) begin
                            seq_q <= ATC_POST;
                        end
                    end
                    ATC_POST: begin
                        if (remain_q == '0 && !in_scan_q) begin
                            seq_q <= ATC_IDLE;
                        end else if (scan_go) begin
                            remain_q <= remain_q - 1'b1;
                        end
                    end
                    default: seq_q <= ATC_IDLE;
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // Scan and conversion timing
    // ------------------------------------------------------------
    logic [CW-1:0] ci_q;
    logic [CW-1:0] nconv_q;

    assign conv_go   = in_scan_q && (is_int(route_q, SIG_CONV) ? (ci_q == '0) : edg[SIG_CONV]);
    assign last_conv = conv_go && (nconv_q <= CW'(1));

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            in_scan_q <= 1'b0;
            ci_q      <= '0;
            nconv_q   <= '0;
        end else if (ce) begin
            if (cmd_stop || last_conv) begin
                in_scan_q <= 1'b0;
                ci_q      <= conv_ivl_q;
            end else if (scan_go) begin
                in_scan_q <= 1'b1;
                ci_q      <= conv_ivl_q;
                nconv_q   <= conv_num_q;
            end else if (in_scan_q) begin
                ci_q <= (ci_q == '0) ? conv_ivl_q : ci_q - 1'b1;
                if (conv_go) begin
                    nconv_q <= nconv_q - 1'b1;
                end
            end else begin
                ci_q <= conv_ivl_q;
            end
        end
    end

    // ------------------------------------------------------------
    // Output pulses: start, reference, scan, convert
    // ------------------------------------------------------------
    logic [3:0] pev;
    logic [3:0] pout_q;
    logic [3:0] pt_q [4];
    logic       scan_o_q;

    assign pev = {conv_go, scan_go, ref_ev, start_ev};

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            pout_q <= 4'h8;
            for (int i = 0; i < 4; i++) begin
                pt_q[i] <= 4'h0;
            end
        end else if (ce) begin
            for (int i = 0; i < 4; i++) begin
                pt_q[i]   <= pev[i] ? 4'(OUT_PULSE_CYC) : ((pt_q[i] != 4'h0) ? pt_q[i] - 4'h1 : 4'h0);
                // Convert output is active low
                pout_q[i] <= (pev[i] || pt_q[i] > 4'h1) ^ (i == 3);
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            scan_o_q <= 1'b0;
        end else if (ce) begin
            if (ctrl_q[CTRL_SCAN_LVL]) begin
                scan_o_q <= scan_go || (in_scan_q && !last_conv && !cmd_stop);
            end else begin
                scan_o_q <= scan_go || pt_q[2] > 4'h1;
            end
        end
    end

    // ------------------------------------------------------------
    // Sample-done pulse
    // ------------------------------------------------------------
    logic [3:0] sd_dly_q;
    logic [5:0] sd_w_q;
    logic       sdone_q;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            sd_dly_q <= 4'h0;
            sd_w_q   <= 6'h00;
            sdone_q  <= 1'b0;
        end else if (ce) begin
            if (conv_go && ctrl_q[CTRL_SD_EN]) begin
                sd_dly_q <= 4'(SD_DELAY_CYC);
            end else if (sd_dly_q != 4'h0) begin
                sd_dly_q <= sd_dly_q - 4'h1;
            end
            if (sd_dly_q == 4'h1) begin
                sd_w_q <= 6'(SD_WIDTH_CYC);
            end else if (sd_w_q != 6'h00) begin
                sd_w_q <= sd_w_q - 6'h01;
            end
            sdone_q <= ctrl_q[CTRL_SD_POL] ^ (sd_dly_q == 4'h1 || sd_w_q > 6'h01);
        end
    end

    assign pins.start_o  = pout_q[0];
    assign pins.ref_o    = pout_q[1];
    assign pins.conv_o_n = pout_q[3];
    assign pins.scan_o   = scan_o_q;
    assign pins.sdone_o  = sdone_q;
    assign pins.start_oe = ctrl_q[CTRL_START_OE];
    assign pins.ref_oe   = ctrl_q[CTRL_REF_OE];
    assign pins.scan_oe  = ctrl_q[CTRL_SCAN_OE];
    assign pins.conv_oe  = ctrl_q[CTRL_CONV_OE];
endmodule : atc_dev

// File: design/atc_pkg.sv
package atc_pkg;
    // ------------------------------------------------------------
    // Clock and timing
    // ------------------------------------------------------------
    localparam int CLK_NS        = 10;
    localparam int CLK_MHZ       = 100;
    localparam int OUT_PULSE_NS  = 50;
    localparam int OUT_PULSE_CYC = (OUT_PULSE_NS + CLK_NS - 1) / CLK_NS;
    localparam int SD_DELAY_NS   = 50;
    localparam int SD_DELAY_CYC  = (SD_DELAY_NS + CLK_NS - 1) / CLK_NS;
    localparam int SD_WIDTH_NS   = 400;
    localparam int SD_WIDTH_CYC  = (SD_WIDTH_NS + CLK_NS - 1) / CLK_NS;
    localparam int EDGE_MIN_NS   = 10;
    localparam int EDGE_MIN_CYC  = (EDGE_MIN_NS + CLK_NS - 1) / CLK_NS;
    localparam int TBASE_MIN_NS  = 23;
    localparam int TBASE_MIN_CYC = (TBASE_MIN_NS + CLK_NS - 1) / CLK_NS;
    localparam int TB_FAST_MHZ   = 20;
    localparam int TB_FAST_CYC   = CLK_MHZ / TB_FAST_MHZ;
    localparam int TB_SLOW_KHZ   = 100;
    localparam int TB_SLOW_CYC   = CLK_MHZ * 1000 / TB_SLOW_KHZ;

    // ------------------------------------------------------------
    // Routable inputs: 0 front input, 1..6 backplane lines, 7 star
    // ------------------------------------------------------------
    localparam int          NUM_LINES = 8;
    localparam logic [3:0]  SRC_INTERNAL = 4'h8;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] REG_CTRL     = 8'h00;
    localparam logic [7:0] REG_ROUTE    = 8'h04;
    localparam logic [7:0] REG_POL      = 8'h08;
    localparam logic [7:0] REG_SCAN_IVL = 8'h0C;
    localparam logic [7:0] REG_CONV_IVL = 8'h10;
    localparam logic [7:0] REG_PRE_CNT  = 8'h14;
    localparam logic [7:0] REG_POST_CNT = 8'h18;
    localparam logic [7:0] REG_CONV_NUM = 8'h1C;
    localparam logic [7:0] REG_CMD      = 8'h20;
    localparam logic [7:0] REG_STATUS   = 8'h24;
    localparam logic [7:0] REG_REMAIN   = 8'h28;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int CTRL_PRETRIG   = 0;
    localparam int CTRL_START_OE  = 1;
    localparam int CTRL_REF_OE    = 2;
    localparam int CTRL_SCAN_OE   = 3;
    localparam int CTRL_CONV_OE   = 4;
    localparam int CTRL_SCAN_LVL  = 5;
    localparam int CTRL_SD_EN     = 6;
    localparam int CTRL_SD_POL    = 7;
    localparam int CTRL_SW_GATE   = 8;
    localparam int CTRL_TB_SLOW   = 9;
    localparam int CTRL_W         = 10;

    // Source fields of the route register, four bits each
    localparam int SIG_START = 0;
    localparam int SIG_REF   = 1;
    localparam int SIG_SCAN  = 2;
    localparam int SIG_CONV  = 3;
    localparam int SIG_GATE  = 4;
    localparam int SIG_TBASE = 5;
    localparam int NUM_SIGS  = 6;

    localparam int CMD_START = 0;
    localparam int CMD_STOP  = 1;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [CTRL_W-1:0]     CTRL_RST     = 10'h000;
    localparam logic [NUM_SIGS*4-1:0] ROUTE_RST    = 24'h888888;
    localparam logic [NUM_SIGS-1:0]   POL_RST      = 6'h00;
    localparam logic [31:0]           IVL_RST      = 32'h0000_0001;
    localparam logic [31:0]           COUNT_RST    = 32'h0000_0001;

    typedef enum logic [1:0] {
        ATC_IDLE,
        ATC_PRE,
        ATC_WAIT_REF,
        ATC_POST
    } atc_seq_t;
endpackage : atc_pkg

// File: design/atc_if.sv
`timescale 1ns/10ps
interface atc_if;
    logic [7:0] trig;
    logic       start_o;
    logic       start_oe;
    logic       ref_o;
    logic       ref_oe;
    logic       scan_o;
    logic       scan_oe;
    logic       conv_o_n;
    logic       conv_oe;
    logic       sdone_o;

    modport dev (
        input  trig,
        output start_o, start_oe, ref_o, ref_oe, scan_o, scan_oe, conv_o_n, conv_oe, sdone_o
    );
    modport ext (
        output trig,
        input  start_o, start_oe, ref_o, ref_oe, scan_o, scan_oe, conv_o_n, conv_oe, sdone_o
    );
endinterface : atc_if

// File: design/atc_ext.sv
`timescale 1ns/10ps
module atc_ext #(
    parameter int GAP_CYC  = 2,
    parameter int TB_LINE  = 7,
    parameter int TB_HALF  = 3
) (
    input  wire logic       mclk,
    input  wire logic       rst_n,
    input  wire logic       ce,
    input  wire logic [7:0] pulse_req,
    input  wire logic [7:0] idle_lvl,
    input  wire logic       tb_en,
    output logic      [7:0] busy,
    output logic      [4:0] seen,
    atc_if.ext              pins
);
    import atc_pkg::*;

    // ------------------------------------------------------------
    // Edge pulses with minimum width and spacing
    // ------------------------------------------------------------
    localparam int HOLD = (EDGE_MIN_CYC > 1) ? EDGE_MIN_CYC : 1;
    localparam int HALF = (TB_HALF > TBASE_MIN_CYC) ? TB_HALF : TBASE_MIN_CYC;

    logic [7:0] cnt_q [8];
    logic [7:0] pls_q;
    logic [7:0] busy_q;
    logic [7:0] tb_cnt_q;
    logic       tb_q;
    logic [7:0] trig_q;
    logic [4:0] seen_q;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            pls_q  <= 8'h00;
            busy_q <= 8'h00;
            for (int i = 0; i < 8; i++) begin
                cnt_q[i] <= 8'h00;
            end
        end else if (ce) begin
            for (int i = 0; i < 8; i++) begin
                if (pulse_req[i] && cnt_q[i] == 8'h00) begin
                    cnt_q[i]  <= 8'(HOLD + GAP_CYC);
                    pls_q[i]  <= 1'b1;
                    busy_q[i] <= 1'b1;
                end else if (cnt_q[i] != 8'h00) begin
                    cnt_q[i]  <= cnt_q[i] - 8'h01;
                    pls_q[i]  <= cnt_q[i] > 8'(GAP_CYC + 1);
                    busy_q[i] <= cnt_q[i] > 8'h01;
                end else begin
                    pls_q[i]  <= 1'b0;
                    busy_q[i] <= 1'b0;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Timebase: each phase held at least the minimum time
    // ------------------------------------------------------------
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            tb_cnt_q <= 8'h00;
            tb_q     <= 1'b0;
        end else if (ce) begin
            if (!tb_en) begin
                tb_cnt_q <= 8'h00;
                tb_q     <= 1'b0;
            end else if (tb_cnt_q == 8'(HALF - 1)) begin
                tb_cnt_q <= 8'h00;
                tb_q     <= ~tb_q;
            end else begin
                tb_cnt_q <= tb_cnt_q + 8'h01;
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            trig_q <= 8'h00;
            seen_q <= 5'h00;
        end else if (ce) begin
            for (int i = 0; i < 8; i++) begin
                trig_q[i] <= (tb_en && i == TB_LINE) ? tb_q : (idle_lvl[i] ^ pls_q[i]);
            end
            seen_q <= {pins.sdone_o,
                       pins.conv_oe  & ~pins.conv_o_n,
                       pins.scan_oe  & pins.scan_o,
                       pins.ref_oe   & pins.ref_o,
                       pins.start_oe & pins.start_o};
        end
    end

    assign pins.trig = trig_q;
    assign busy      = busy_q;
    assign seen      = seen_q;
endmodule : atc_ext

// File: dv/atc_sva.sv
`timescale 1ns/10ps
module atc_sva (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic start_o,
    input wire logic start_oe,
    input wire logic ref_o,
    input wire logic ref_oe,
    input wire logic scan_oe,
    input wire logic conv_o_n,
    input wire logic conv_oe,
    input wire logic sdone_o
);
    // ------------------------------------------------------------
    // Output enable and pulse checks
    // ------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    chk_start_hiz: assert property ($rose(rst_n) |-> !start_oe) else $error("start enable on");
    chk_outs_hiz: assert property ($rose(rst_n) |-> !(ref_oe || scan_oe || conv_oe)) else $error("enable on");
    chk_start_width: assert property ($rose(start_o) |-> start_o [*5] ##1 !start_o) else $error("start width");
    chk_ref_width: assert property ($rose(ref_o) |-> ref_o [*5] ##1 !ref_o) else $error("ref width");
    chk_ref_apart: assert property ($rose(ref_o) |-> !start_o) else $error("ref beside start");
    chk_conv_width: assert property ($fell(conv_o_n) |-> !conv_o_n [*5] ##1 conv_o_n) else $error("conv width");
    chk_sdone_lead: assert property ($fell(conv_o_n) |-> ##[4:6] sdone_o) else $error("done late");
    chk_sdone_width: assert property ($rose(sdone_o) |-> ##39 sdone_o ##1 !sdone_o) else $error("done width");
    cover_start: cover property ($rose(start_o));
    cover_ref: cover property ($rose(ref_o));
    cover_conv: cover property ($fell(conv_o_n));
endmodule : atc_sva

// File: dv/atc_tb_top.sv
`timescale 1ns/10ps
module atc_tb_top;
    import atc_pkg::*;
    typedef struct {logic [3:0] src; logic pre; logic [7:0] post; logic [7:0] cnum; int convs;} atc_row_t;
    atc_row_t    rows [4] = '{'{4'h8, 1'b0, 8'h02, 8'h02, 4}, '{4'h0, 1'b0, 8'h01, 8'h03, 3},
                              '{4'h7, 1'b0, 8'h03, 8'h01, 3}, '{4'h8, 1'b1, 8'h01, 8'h01, -1}};
    logic        mclk, rst_n, wr, rd;
    logic [7:0]  addr, pulse_req, idle;
    logic [31:0] wdata, rdata, v;
    int          n_mismatch = 0, checks = 0, n_conv, n_ref, n_scan;
    atc_if       pins_if ();
    atc_dev u_atc_dev (.mclk(mclk), .rst_n(rst_n), .ce(1'b1), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
                       .rdata(rdata), .pins(pins_if.dev));
    atc_ext u_atc_ext (.mclk(mclk), .rst_n(rst_n), .ce(1'b1), .pulse_req(pulse_req), .idle_lvl(idle),
                       .tb_en(1'b0), .busy(), .seen(), .pins(pins_if.ext));
    atc_sva u_atc_sva (.mclk(mclk), .rst_n(rst_n), .start_o(pins_if.start_o), .start_oe(pins_if.start_oe),
                       .ref_o(pins_if.ref_o), .ref_oe(pins_if.ref_oe), .scan_oe(pins_if.scan_oe),
                       .conv_o_n(pins_if.conv_o_n), .conv_oe(pins_if.conv_oe), .sdone_o(pins_if.sdone_o));
    // ------------------------------------------------------------
    // Stimulus and checks
    // ------------------------------------------------------------
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    always @(negedge pins_if.conv_o_n) n_conv++;
    always @(posedge pins_if.ref_o) n_ref++;
    always @(posedge pins_if.scan_o) n_scan++;
    task automatic end_sim;
        if (n_mismatch == 0 && checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : end_sim
    task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("[FAIL] %s expected %0h seen %0h", nm, e, g);
        end
    endtask : cmp
    // One register cycle; read data lands in v
    task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        addr <= a;
        wdata <= d;
        wr <= w;
        rd <= !w;
        @(posedge mclk);
        wr <= 1'b0;
        rd <= 1'b0;
        #1;
        v = rdata;
    endtask : acc
    task automatic pulse(input logic [2:0] k);
        @(posedge mclk);
        pulse_req[k] <= 1'b1;
        @(posedge mclk);
        pulse_req <= 8'h00;
    endtask : pulse
    task automatic wait_seq(input logic [1:0] s);
        int i = 0;
        do begin
            acc(1'b0, REG_STATUS, 32'h0);
            i++;
        end while (v[1:0] !== s && i < 3000);
        if (v[1:0] !== s) begin
            n_mismatch++;
            end_sim();
        end
    endtask : wait_seq
    initial begin
        rst_n = 1'b0;
        {addr, wdata, wr, rd, pulse_req, idle} = '0;
        repeat (10) @(posedge mclk);
        rst_n <= 1'b1;
        acc(1'b1, REG_SCAN_IVL, 32'h31);
        acc(1'b1, REG_CONV_IVL, 32'h3B);
        foreach (rows[r]) begin
            acc(1'b1, REG_CTRL, {31'h2F, rows[r].pre});
            acc(1'b1, REG_ROUTE, {8'h00, 16'h8888, 4'h1, rows[r].src});
            acc(1'b1, REG_POST_CNT, {24'h0, rows[r].post});
            acc(1'b1, REG_CONV_NUM, {24'h0, rows[r].cnum});
            n_conv = 0;
            n_ref = 0;
            n_scan = 0;
            if (rows[r].src[3]) acc(1'b1, REG_CMD, 32'h1);
            else pulse(rows[r].src[2:0]);
            if (rows[r].pre) pulse(3'h1);
            wait_seq(rows[r].pre ? 2'h2 : 2'h3);
            if (rows[r].pre) pulse(3'h1);
            wait_seq(2'h0);
            cmp("refs", {31'h0, rows[r].pre}, n_ref);
            if (rows[r].convs >= 0) cmp("converts", rows[r].convs, n_conv);
            if (!rows[r].pre) cmp("scans", {24'h0, rows[r].post}, n_scan);
        end
        n_conv = 0;
        acc(1'b1, REG_CTRL, 32'h15E);
        acc(1'b1, REG_CMD, 32'h1);
        repeat (600) @(posedge mclk);
        cmp("gated converts", 32'h0, n_conv);
        acc(1'b1, REG_CMD, 32'h2);
        // Gate from line 2 with inverted polarity: idle low means gated
        acc(1'b1, REG_CTRL, 32'h5E);
        acc(1'b1, REG_ROUTE, 32'h828818);
        acc(1'b1, REG_POL, 32'h10);
        acc(1'b1, REG_CMD, 32'h1);
        repeat (600) @(posedge mclk);
        cmp("pin gated converts", 32'h0, n_conv);
        idle[2] <= 1'b1;
        wait_seq(2'h0);
        cmp("ungated converts", 32'h1, n_conv);
        rst_n <= 1'b0;
        repeat (10) @(posedge mclk);
        rst_n <= 1'b1;
        acc(1'b0, REG_ROUTE, 32'h0);
        cmp("route", 32'h888888, v);
        cmp("enables", 32'h0, {28'h0, pins_if.start_oe, pins_if.ref_oe, pins_if.scan_oe, pins_if.conv_oe});
        acc(1'b0, 8'hFC, 32'h0);
        cmp("unmapped", 32'h0, v);
        end_sim();
    end
endmodule : atc_tb_top
